// File: common/mgst_consts.svh
// Constants for the management sync and sequence tracker.
`ifndef MGST_CONSTS_SVH
`define MGST_CONSTS_SVH
`define MGST_SEQ_W 8
`define MGST_SEQ_FIRST 8'h01
`define MGST_SEQ_LAST 8'hFF
`define MGST_SEQ_UNDEF 8'h00
`define MGST_CLK_HZ 10000000
`define MGST_TICK_SEC 1
`define MGST_CFG_TMO_SEC 60
`define MGST_ALM_TMO_SEC 60
`define MGST_TBL_TMO_SEC 60
`define MGST_TBL_SIZE_BYTES 4
`define MGST_CNT_W 16
`define MGST_SIZE_W 32
`endif

// File: common/mgst_pkg.sv
// Types shared by the management sync and sequence tracker.
package mgst_pkg;
	// Session states, Gray coded along idle, open, expired.
	typedef enum logic [1:0] {
		MGST_S_IDLE = 2'b00,
		MGST_S_OPEN = 2'b01,
		MGST_S_DONE = 2'b11
	} mgst_sess_t;
endpackage

// File: hw/mgst_tick_gen.sv
// One-second tick divider from the system clock.
`timescale 1ns/1ps
`include "mgst_consts.svh"
module mgst_tick_gen #(
	parameter int unsigned DIV = `MGST_CLK_HZ * `MGST_TICK_SEC
) (
	input wire logic clk_i,
	input wire logic rst_b_i,
	input wire logic en_i,
	output logic tick_o
);
	import mgst_pkg::*;
	localparam int unsigned W = (DIV > 1) ? $clog2(DIV) : 1;
	logic [W-1:0] cnt_q; // Cycles since the last tick.
	wire at_end = (cnt_q == W'(DIV - 1));
	// Free-running divider; the tick is a single-cycle pulse.
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			cnt_q <= '0;
			tick_o <= 1'b0;
		end else if (en_i) begin
			cnt_q <= at_end ? '0 : cnt_q + 1'b1;
			tick_o <= at_end;
		end
	end
endmodule

// File: hw/mgst_sess_timer.sv
// Retrieval session timer with a count of expected next requests.
`timescale 1ns/1ps
`include "mgst_consts.svh"
module mgst_sess_timer #(
	parameter int unsigned TMO_SEC = 60
) (
	input wire logic clk_i,
	input wire logic rst_b_i,
	input wire logic en_i,
	input wire logic tick_i,
	input wire logic start_i,
	input wire logic [`MGST_CNT_W-1:0] count_i,
	input wire logic next_i,
	output logic open_o,
	output logic accept_o,
	output logic reject_o,
	output logic expire_o,
	output logic [`MGST_CNT_W-1:0] remain_o
);
	import mgst_pkg::*;
	mgst_sess_t st_q;
	logic [7:0] sec_q; // Whole seconds since the last restart.
	// A next is accepted only while open and items remain.
	wire ok_next = next_i && !start_i && (st_q == MGST_S_OPEN) && (remain_o != '0);
	wire tmo = (st_q == MGST_S_OPEN) && tick_i && (sec_q == 8'(TMO_SEC - 1));
	assign open_o = (st_q == MGST_S_OPEN);
	assign accept_o = ok_next;
	assign reject_o = next_i && !start_i && !ok_next;
	// A start always wins; it reopens the session and clears the clock.
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			st_q <= MGST_S_IDLE;
			sec_q <= '0;
			remain_o <= '0;
			expire_o <= 1'b0;
		end else if (en_i) begin
			expire_o <= tmo && !start_i && !ok_next;
			if (start_i) begin
				st_q <= MGST_S_OPEN;
				sec_q <= '0;
				remain_o <= count_i;
			end else if (ok_next) begin
				sec_q <= '0;
				remain_o <= remain_o - 1'b1;
			end else if (tmo) begin
				// Snapshot is dropped; later nexts read as out of range.
				st_q <= MGST_S_DONE;
				remain_o <= '0;
			end else if (open_o && tick_i) begin
				sec_q <= sec_q + 1'b1;
			end
		end
	end
endmodule

// File: hw/mgst_top.sv
// Configuration and alarm sequence counters with retrieval session timers.
// Function
// - Hold eight-bit configuration sequence counter, readable.
// - Commanded create or delete advances counter.
// - Commanded attribute change advances counter.
// - One step per executed command only.
// - Autonomous changes leave counter unchanged.
// - Update and increment are applied together.
// - Configuration counter wraps 255 to 1.
// - Config dump ends after one idle minute.
// - Tables, monitors, descriptors excluded from dump.
// - Alarm notifications carry eight-bit sequence.
// - Alarm sequence starts 1, wraps, skips zero.
// - Alarm dump start resets alarm sequence.
// - Alarm dump ends after one idle minute.
// - Table read answers four-byte size.
// - Table write one entry; oversized entries read-only.
// - Table read ends after sixty idle seconds.
`timescale 1ns/1ps
`include "mgst_consts.svh"
module mgst_top #(
	parameter int unsigned TICK_DIV = `MGST_CLK_HZ * `MGST_TICK_SEC,
	parameter int unsigned MAX_WR_BYTES = 29
) (
	input wire logic clk_i,
	input wire logic rst_b_i,
	input wire logic en_i,
	// Executed command strobe and its kind.
	input wire logic cmd_done_i,
	input wire logic cmd_from_head_i,
	input wire logic cmd_changes_i,
	// Head end writes the sequence value during resync.
	input wire logic seq_wr_i,
	input wire logic [`MGST_SEQ_W-1:0] seq_wr_data_i,
	// Restore failed or factory default; forces the undefined value.
	input wire logic seq_undef_i,
	output logic [`MGST_SEQ_W-1:0] config_change_seq_o,
	output logic cfg_commit_o,
	// Alarm notification request and its sequence number.
	input wire logic alarm_send_i,
	output logic [`MGST_SEQ_W-1:0] alarm_seq_o,
	// Config dump session.
	input wire logic config_dump_start_i,
	input wire logic [`MGST_CNT_W-1:0] config_dump_count_i,
	input wire logic config_dump_next_req_i,
	input wire logic [2:0] dump_item_class_i,
	output logic config_dump_open_o,
	output logic config_dump_accept_o,
	output logic config_dump_reject_o,
	output logic config_dump_skip_o,
	output logic config_dump_expire_o,
	// Alarm dump session.
	input wire logic alarm_dump_start_i,
	input wire logic [`MGST_CNT_W-1:0] alarm_dump_count_i,
	input wire logic alarm_dump_next_req_i,
	output logic alarm_dump_open_o,
	output logic alarm_dump_accept_o,
	output logic alarm_dump_reject_o,
	output logic alarm_dump_expire_o,
	// Table attribute access.
	input wire logic tbl_get_i,
	input wire logic [`MGST_SIZE_W-1:0] tbl_size_i,
	input wire logic [`MGST_CNT_W-1:0] tbl_next_count_i,
	input wire logic tbl_next_req_i,
	input wire logic tbl_set_i,
	input wire logic [`MGST_CNT_W-1:0] tbl_set_entries_i,
	input wire logic [7:0] tbl_entry_bytes_i,
	output logic [`MGST_SIZE_W-1:0] tbl_size_o,
	output logic [2:0] tbl_size_len_o,
	output logic tbl_read_open_o,
	output logic tbl_read_accept_o,
	output logic tbl_read_reject_o,
	output logic tbl_read_expire_o,
	output logic tbl_set_ok_o,
	output logic tbl_set_reject_o
);
	import mgst_pkg::*;

	// Dump item classes; all but CLS_PLAIN never enter the configuration dump.
	localparam logic [2:0] CLS_PLAIN = 3'h0;
	localparam logic [2:0] CLS_TABLE = 3'h1;
	localparam logic [2:0] CLS_PERF = 3'h2;
	localparam logic [2:0] CLS_DESC = 3'h3;

	// Sequence advance shared by both counters; zero is never produced.
	function automatic logic [`MGST_SEQ_W-1:0] seq_next(input logic [`MGST_SEQ_W-1:0] v);
		seq_next = (v == `MGST_SEQ_LAST) ? `MGST_SEQ_FIRST : v + 1'b1;
	endfunction

	logic [`MGST_SEQ_W-1:0] cfg_seq_q; // Configuration sequence value.
	logic [`MGST_SEQ_W-1:0] alm_seq_q; // Last alarm sequence sent.
	logic commit_q; // Marks the cycle where update and increment land.
	logic tick; // One-second tick.

	// Only a head-end command that changed something counts, once.
	wire cfg_bump = cmd_done_i && cmd_from_head_i && cmd_changes_i;

	// A single register step keeps the increment atomic with the commit pulse.
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			cfg_seq_q <= `MGST_SEQ_UNDEF;
			commit_q <= 1'b0;
		end else if (en_i) begin
			commit_q <= cfg_bump || seq_wr_i;
			if (seq_undef_i) begin
				cfg_seq_q <= `MGST_SEQ_UNDEF;
			end else if (seq_wr_i) begin
				cfg_seq_q <= seq_wr_data_i;
			end else if (cfg_bump) begin
				cfg_seq_q <= seq_next(cfg_seq_q);
			end
		end
	end
	assign config_change_seq_o = cfg_seq_q;
	assign cfg_commit_o = commit_q;

	// Alarm sequence: the value after a restart or dump start is 1 for the next send.
	wire [`MGST_SEQ_W-1:0] alm_cur = (alm_seq_q == `MGST_SEQ_UNDEF) ? `MGST_SEQ_FIRST : seq_next(alm_seq_q);
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			alm_seq_q <= `MGST_SEQ_UNDEF;
		end else if (en_i) begin
			if (alarm_dump_start_i) begin
				alm_seq_q <= `MGST_SEQ_UNDEF;
			end else if (alarm_send_i) begin
				alm_seq_q <= alm_cur;
			end
		end
	end
	// The output shows the number carried by a send in this cycle.
	assign alarm_seq_o = alm_cur;

	mgst_tick_gen #(.DIV(TICK_DIV)) u_tick (
		.clk_i(clk_i),
		.rst_b_i(rst_b_i),
		.en_i(en_i),
		.tick_o(tick)
	);

	// Three session timers restarted by start and every accepted next.
	logic [`MGST_CNT_W-1:0] cfg_rem; // Remaining dump items.
	mgst_sess_timer #(.TMO_SEC(`MGST_CFG_TMO_SEC)) u_cfg (
		.clk_i(clk_i),
		.rst_b_i(rst_b_i),
		.en_i(en_i),
		.tick_i(tick),
		.start_i(config_dump_start_i),
		.count_i(config_dump_count_i),
		.next_i(config_dump_next_req_i),
		.open_o(config_dump_open_o),
		.accept_o(config_dump_accept_o),
		.reject_o(config_dump_reject_o),
		.expire_o(config_dump_expire_o),
		.remain_o(cfg_rem)
	);
	// Items of excluded classes are flagged so the formatter leaves them out.
	wire excl = (dump_item_class_i == CLS_TABLE) || (dump_item_class_i == CLS_PERF)
		|| (dump_item_class_i == CLS_DESC);
	assign config_dump_skip_o = config_dump_accept_o && excl;

	logic [`MGST_CNT_W-1:0] alm_rem; // Remaining alarm instances.
	mgst_sess_timer #(.TMO_SEC(`MGST_ALM_TMO_SEC)) u_alm (
		.clk_i(clk_i),
		.rst_b_i(rst_b_i),
		.en_i(en_i),
		.tick_i(tick),
		.start_i(alarm_dump_start_i),
		.count_i(alarm_dump_count_i),
		.next_i(alarm_dump_next_req_i),
		.open_o(alarm_dump_open_o),
		.accept_o(alarm_dump_accept_o),
		.reject_o(alarm_dump_reject_o),
		.expire_o(alarm_dump_expire_o),
		.remain_o(alm_rem)
	);

	logic [`MGST_CNT_W-1:0] tbl_rem; // Remaining table segments.
	mgst_sess_timer #(.TMO_SEC(`MGST_TBL_TMO_SEC)) u_tbl (
		.clk_i(clk_i),
		.rst_b_i(rst_b_i),
		.en_i(en_i),
		.tick_i(tick),
		.start_i(tbl_get_i),
		.count_i(tbl_next_count_i),
		.next_i(tbl_next_req_i),
		.open_o(tbl_read_open_o),
		.accept_o(tbl_read_accept_o),
		.reject_o(tbl_read_reject_o),
		.expire_o(tbl_read_expire_o),
		.remain_o(tbl_rem)
	);

	// Plain read of a table answers its size, laid out as a four-byte attribute.
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			tbl_size_o <= '0;
			tbl_size_len_o <= 3'h0;
		end else if (en_i && tbl_get_i) begin
			tbl_size_o <= tbl_size_i;
			tbl_size_len_o <= 3'(`MGST_TBL_SIZE_BYTES);
		end
	end

	// A set touches one entry; oversized entries make the table read-only.
	wire set_ok = (tbl_set_entries_i == 16'h0001) && (tbl_entry_bytes_i <= 8'(MAX_WR_BYTES));
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			tbl_set_ok_o <= 1'b0;
			tbl_set_reject_o <= 1'b0;
		end else if (en_i) begin
			tbl_set_ok_o <= tbl_set_i && set_ok;
			tbl_set_reject_o <= tbl_set_i && !set_ok;
		end
	end

	// Checks.
	sequence s_bump;
		en_i && cfg_bump && !seq_wr_i && !seq_undef_i;
	endsequence
	property p_cfg_step;
		@(posedge clk_i) disable iff (!rst_b_i) s_bump |=> (cfg_seq_q == seq_next($past(cfg_seq_q)));
	endproperty
	a_cfg_step: assert property (p_cfg_step) else $error("config sequence step wrong");
	property p_cfg_auto;
		@(posedge clk_i) disable iff (!rst_b_i)
			(en_i && cmd_done_i && !cmd_from_head_i && !seq_wr_i && !seq_undef_i) |=> $stable(cfg_seq_q);
	endproperty
	a_cfg_auto: assert property (p_cfg_auto) else $error("autonomous change moved sequence");
	property p_cfg_nz;
		@(posedge clk_i) disable iff (!rst_b_i) s_bump |=> (cfg_seq_q != 8'h00);
	endproperty
	a_cfg_nz: assert property (p_cfg_nz) else $error("config sequence reached zero");
	property p_commit;
		@(posedge clk_i) disable iff (!rst_b_i) s_bump |=> (commit_q && $changed(cfg_seq_q));
	endproperty
	a_commit: assert property (p_commit) else $error("commit and increment apart");
	property p_alm_nz;
		@(posedge clk_i) disable iff (!rst_b_i) alarm_send_i |-> (alarm_seq_o != 8'h00);
	endproperty
	a_alm_nz: assert property (p_alm_nz) else $error("alarm sequence zero sent");
	property p_alm_reset;
		@(posedge clk_i) disable iff (!rst_b_i) (en_i && alarm_dump_start_i) |=> (alarm_seq_o == 8'h01);
	endproperty
	a_alm_reset: assert property (p_alm_reset) else $error("alarm sequence not reset");
	property p_tbl_len;
		@(posedge clk_i) disable iff (!rst_b_i) (en_i && tbl_get_i) |=> (tbl_size_len_o == 3'h4);
	endproperty
	a_tbl_len: assert property (p_tbl_len) else $error("table size length wrong");
	property p_set_multi;
		@(posedge clk_i) disable iff (!rst_b_i) (en_i && tbl_set_i && tbl_set_entries_i > 16'h0001) |=> tbl_set_reject_o;
	endproperty
	a_set_multi: assert property (p_set_multi) else $error("multi-entry set accepted");
	property p_skip;
		@(posedge clk_i) disable iff (!rst_b_i) (config_dump_accept_o && dump_item_class_i == CLS_PERF) |-> config_dump_skip_o;
	endproperty
	a_skip: assert property (p_skip) else $error("excluded item not skipped");
	property p_exp_closed;
		@(posedge clk_i) disable iff (!rst_b_i) config_dump_expire_o |-> !config_dump_open_o;
	endproperty
	a_exp_closed: assert property (p_exp_closed) else $error("dump open after expiry");

	// Config counter: forced undefined value, head-end write and idle hold.
	// A drifting counter would make every later audit report a false mismatch.
	property p_undef;
		@(posedge clk_i) disable iff (!rst_b_i) (en_i && seq_undef_i) |=> (cfg_seq_q == 8'h00);
	endproperty
	a_undef: assert property (p_undef) else $error("undefined value not forced");
	property p_wr_load;
		@(posedge clk_i) disable iff (!rst_b_i)
			(en_i && seq_wr_i && !seq_undef_i) |=> (commit_q && cfg_seq_q == $past(seq_wr_data_i));
	endproperty
	a_wr_load: assert property (p_wr_load) else $error("sequence write not applied");
	property p_no_cmd;
		@(posedge clk_i) disable iff (!rst_b_i)
			(en_i && !cmd_done_i && !seq_wr_i && !seq_undef_i) |=> $stable(cfg_seq_q);
	endproperty
	a_no_cmd: assert property (p_no_cmd) else $error("sequence moved without a command");

	// Alarm counter: each send without an alarm dump start stores the number that it carried.
	// The next send then offers the following number, so no gap is made.
	property p_alm_step;
		@(posedge clk_i) disable iff (!rst_b_i)
			(en_i && alarm_send_i && !alarm_dump_start_i) |=> (alm_seq_q == $past(alarm_seq_o));
	endproperty
	a_alm_step: assert property (p_alm_step) else $error("alarm sequence not stored");

	// Every start opens its session at the next edge, whatever state it left.
	// A restart over a live session is legal and simply takes a fresh snapshot.
	property p_cfg_start;
		@(posedge clk_i) disable iff (!rst_b_i) (en_i && config_dump_start_i) |=> config_dump_open_o;
	endproperty
	a_cfg_start: assert property (p_cfg_start) else $error("config dump not opened");
	property p_alm_start;
		@(posedge clk_i) disable iff (!rst_b_i) (en_i && alarm_dump_start_i) |=> alarm_dump_open_o;
	endproperty
	a_alm_start: assert property (p_alm_start) else $error("alarm dump not opened");
	property p_tbl_start;
		@(posedge clk_i) disable iff (!rst_b_i) (en_i && tbl_get_i) |=> tbl_read_open_o;
	endproperty
	a_tbl_start: assert property (p_tbl_start) else $error("table read not opened");

	// An expiry closes the session and leaves nothing to fetch.
	// With no items left, any later next is refused as out of range.
	property p_cfg_drop;
		@(posedge clk_i) disable iff (!rst_b_i) config_dump_expire_o |-> (cfg_rem == 16'h0000);
	endproperty
	a_cfg_drop: assert property (p_cfg_drop) else $error("config dump kept items after expiry");
	property p_alm_exp_closed;
		@(posedge clk_i) disable iff (!rst_b_i)
			alarm_dump_expire_o |-> (!alarm_dump_open_o && alm_rem == 16'h0000);
	endproperty
	a_alm_exp_closed: assert property (p_alm_exp_closed) else $error("alarm dump open after expiry");
	property p_tbl_exp_closed;
		@(posedge clk_i) disable iff (!rst_b_i)
			tbl_read_expire_o |-> (!tbl_read_open_o && tbl_rem == 16'h0000);
	endproperty
	a_tbl_exp_closed: assert property (p_tbl_exp_closed) else $error("table read open after expiry");

	// An accepted next uses up exactly one item of the snapshot.
	// Counting down is what lets the session refuse one next too many.
	sequence s_cfg_take;
		en_i && config_dump_accept_o;
	endsequence
	property p_cfg_take;
		@(posedge clk_i) disable iff (!rst_b_i) s_cfg_take |=> (cfg_rem == $past(cfg_rem) - 16'h0001);
	endproperty
	a_cfg_take: assert property (p_cfg_take) else $error("accepted next did not use an item");

	// Table get holds the reported size; a wide single entry is refused too.
	// The width limit is a parameter, so the check follows whatever it is set to.
	property p_tbl_size;
		@(posedge clk_i) disable iff (!rst_b_i) (en_i && tbl_get_i) |=> (tbl_size_o == $past(tbl_size_i));
	endproperty
	a_tbl_size: assert property (p_tbl_size) else $error("table size not held");
	property p_set_wide;
		@(posedge clk_i) disable iff (!rst_b_i)
			(en_i && tbl_set_i && tbl_entry_bytes_i > 8'(MAX_WR_BYTES)) |=> tbl_set_reject_o;
	endproperty
	a_set_wide: assert property (p_set_wide) else $error("oversized entry set accepted");
endmodule

// File: bench/mgst_head_model.sv
// Head-end controller model that audits and runs retrieval sessions.
`timescale 1ns/1ps
`include "mgst_consts.svh"
module mgst_head_model (
	input wire logic clk_i,
	input wire logic [`MGST_SEQ_W-1:0] seq_i,
	input wire logic [2:0] acc_i,
	input wire logic [2:0] rej_i,
	output logic seq_wr_o,
	output logic [`MGST_SEQ_W-1:0] seq_data_o,
	output logic [2:0] start_o,
	output logic [2:0] next_o,
	output logic [`MGST_CNT_W-1:0] cnt_o
);
	// All requests rest low until a task raises them.
	initial begin
		seq_wr_o = 1'b0;
		seq_data_o = 8'h00;
		start_o = 3'h0;
		next_o = 3'h0;
		cnt_o = 16'h0000;
	end

	// Opens one session; index 0 config dump, 1 alarm dump, 2 table read.
	// Sessions are run one after another, never overlapped, to spare memory.
	task automatic start(input int s, input logic [`MGST_CNT_W-1:0] n);
		@(negedge clk_i);
		cnt_o = n;
		start_o[s] = 1'b1;
		@(negedge clk_i);
		start_o[s] = 1'b0;
		cnt_o = ~n; // Released count no longer shows the last value.
	endtask

	// One next request; the answer is taken at the edge that samples the request.
	task automatic next(input int s, output logic a, output logic r);
		@(negedge clk_i);
		next_o[s] = 1'b1;
		@(posedge clk_i);
		a = acc_i[s];
		r = rej_i[s];
		@(negedge clk_i);
		next_o[s] = 1'b0;
	endtask

	// Audit: a match needs nothing, a mismatch pushes our own value in one step.
	task automatic audit(input logic [`MGST_SEQ_W-1:0] mine);
		@(negedge clk_i);
		if (seq_i !== mine) begin
			seq_data_o = mine;
			seq_wr_o = 1'b1;
			@(negedge clk_i);
			seq_wr_o = 1'b0;
			seq_data_o = ~mine;
		end
	endtask
endmodule

// File: bench/mgst_top_tb.sv
// Self-checking testbench for the sequence tracker and its sessions.
`timescale 1ns/1ps
`include "mgst_consts.svh"
module mgst_top_tb;
	import mgst_pkg::*;
	// Stimulus starts at rest and only moves at falling edges.
	logic clk_i = 1'b0, rst_b_i = 1'b0, en_i = 1'b1;
	logic cmd_done_i = 1'b0, cmd_from_head_i = 1'b0, cmd_changes_i = 1'b0;
	logic seq_undef_i = 1'b0, alarm_send_i = 1'b0, tbl_set_i = 1'b0;
	logic [2:0] dump_item_class_i = 3'h0;
	logic [`MGST_SIZE_W-1:0] tbl_size_i = 32'h0000_0000;
	logic [`MGST_CNT_W-1:0] tbl_set_entries_i = 16'h0000;
	logic [7:0] tbl_entry_bytes_i = 8'h00;
	// Head-end model requests.
	logic seq_wr;
	logic [`MGST_SEQ_W-1:0] seq_wr_data;
	logic [2:0] st, nx;
	logic [`MGST_CNT_W-1:0] cnt;
	// Results; vector index 0 config dump, 1 alarm dump, 2 table read.
	logic [`MGST_SEQ_W-1:0] config_change_seq_o, alarm_seq_o;
	logic cfg_commit_o, config_dump_skip_o, tbl_set_ok_o, tbl_set_reject_o, skip_q;
	logic [`MGST_SIZE_W-1:0] tbl_size_o;
	logic [2:0] tbl_size_len_o, opn, acc, rej, exq;
	int n_mismatch = 0, cmp_count = 0, cyc = 0;

	// A short tick divider makes one second ten cycles.
	mgst_top #(.TICK_DIV(10)) dut_u (
		.clk_i, .rst_b_i, .en_i, .cmd_done_i, .cmd_from_head_i, .cmd_changes_i,
		.seq_wr_i(seq_wr), .seq_wr_data_i(seq_wr_data), .seq_undef_i, .config_change_seq_o, .cfg_commit_o,
		.alarm_send_i, .alarm_seq_o,
		.config_dump_start_i(st[0]), .config_dump_count_i(cnt), .config_dump_next_req_i(nx[0]), .dump_item_class_i,
		.config_dump_open_o(opn[0]), .config_dump_accept_o(acc[0]), .config_dump_reject_o(rej[0]),
		.config_dump_skip_o, .config_dump_expire_o(exq[0]),
		.alarm_dump_start_i(st[1]), .alarm_dump_count_i(cnt), .alarm_dump_next_req_i(nx[1]),
		.alarm_dump_open_o(opn[1]), .alarm_dump_accept_o(acc[1]), .alarm_dump_reject_o(rej[1]),
		.alarm_dump_expire_o(exq[1]),
		.tbl_get_i(st[2]), .tbl_size_i, .tbl_next_count_i(cnt), .tbl_next_req_i(nx[2]), .tbl_set_i,
		.tbl_set_entries_i, .tbl_entry_bytes_i, .tbl_size_o, .tbl_size_len_o,
		.tbl_read_open_o(opn[2]), .tbl_read_accept_o(acc[2]), .tbl_read_reject_o(rej[2]),
		.tbl_read_expire_o(exq[2]), .tbl_set_ok_o, .tbl_set_reject_o
	);
	mgst_head_model hd_u (.clk_i, .seq_i(config_change_seq_o), .acc_i(acc), .rej_i(rej),
		.seq_wr_o(seq_wr), .seq_data_o(seq_wr_data), .start_o(st), .next_o(nx), .cnt_o(cnt));

	always #50 clk_i = ~clk_i;
	// The skip flag lasts only the cycle of its next request, so it is caught at the edge.
	always @(posedge clk_i) skip_q <= config_dump_skip_o;
	// A hang is cut short far beyond the expected few thousand cycles.
	always @(posedge clk_i) begin
		cyc++;
		if (cyc == 20000) begin
			n_mismatch++;
			stop_test();
		end
	end

	task automatic stop_test();
		$display("comparisons %0d, mismatches %0d", cmp_count, n_mismatch);
		if (n_mismatch == 0 && cmp_count > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	task automatic chk_v(input logic [31:0] got, input logic [31:0] exp, input string what);
		cmp_count++;
		if (got !== exp) begin
			n_mismatch++;
			$display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask

	task automatic chk_b(input logic got, input logic exp, input string what);
		cmp_count++;
		if (got !== exp) begin
			n_mismatch++;
			$display("wrong value at %0t: %s got %b expected %b", $time, what, got, exp);
		end
	endtask

	// One executed changing command; count and commit strobe must show together.
	task automatic bump(input logic head, input logic [7:0] exp, input logic commit);
		@(negedge clk_i);
		cmd_done_i = 1'b1;
		cmd_from_head_i = head;
		cmd_changes_i = 1'b1;
		@(negedge clk_i);
		cmd_done_i = 1'b0;
		chk_v(config_change_seq_o, exp, "config seq");
		chk_b(cfg_commit_o, commit, "commit");
	endtask

	task automatic t_cfg();
		bump(1'b1, 8'h01, 1'b1);
		bump(1'b0, 8'h01, 1'b0);
		bump(1'b1, 8'h02, 1'b1);
		hd_u.audit(8'hFE);
		chk_v(config_change_seq_o, 8'hFE, "resync");
		bump(1'b1, 8'hFF, 1'b1);
		bump(1'b1, 8'h01, 1'b1);
		@(negedge clk_i);
		seq_undef_i = 1'b1;
		@(negedge clk_i);
		seq_undef_i = 1'b0;
		chk_v(config_change_seq_o, 8'h00, "undefined");
		// A command seen while the clock enable is low is not executed.
		@(negedge clk_i);
		en_i = 1'b0;
		cmd_done_i = 1'b1;
		cmd_from_head_i = 1'b1;
		@(negedge clk_i);
		cmd_done_i = 1'b0;
		en_i = 1'b1;
		chk_v(config_change_seq_o, 8'h00, "frozen");
		$display("config sequence test done");
	endtask

	// Back-to-back notifications across the wrap; zero must never be offered.
	task automatic t_alarm();
		logic [7:0] exp;
		exp = 8'h01;
		for (int i = 0; i < 257; i++) begin
			@(negedge clk_i);
			chk_v(alarm_seq_o, exp, "alarm seq");
			alarm_send_i = 1'b1;
			exp = (exp == 8'hFF) ? 8'h01 : exp + 8'h01;
		end
		@(negedge clk_i);
		alarm_send_i = 1'b0;
		$display("alarm sequence test done");
	endtask

	// Counted nexts, one too many, then an idle expiry after a late restart.
	task automatic t_sess(input int s);
		int i;
		logic a, r;
		tbl_size_i = 32'h0001_2345;
		hd_u.start(s, 16'h0004);
		chk_b(opn[s], 1'b1, "open");
		if (s == 1) chk_v(alarm_seq_o, 8'h01, "alarm seq reset");
		if (s == 2) chk_v(tbl_size_o, 32'h0001_2345, "table size");
		if (s == 2) chk_v(tbl_size_len_o, 32'h4, "size length");
		for (i = 0; i < 5; i++) begin
			dump_item_class_i = i[2:0];
			hd_u.next(s, a, r);
			chk_b(a, i < 4, "accept");
			chk_b(r, i == 4, "reject");
			if (s == 0) chk_b(skip_q, i > 0 && i < 4, "skip");
		end
		hd_u.start(s, 16'h0002);
		repeat (300) @(negedge clk_i);
		hd_u.next(s, a, r);
		chk_b(a, 1'b1, "late accept");
		i = 0;
		while (exq[s] !== 1'b1 && i < 700) begin
			@(negedge clk_i);
			i++;
		end
		chk_b(i >= 585 && i <= 612, 1'b1, "idle limit");
		hd_u.next(s, a, r);
		chk_b(r, 1'b1, "next after expiry");
		chk_b(opn[s], 1'b0, "closed");
		$display("session %0d test done", s);
	endtask

	// Single entries up to the default limit of 29 bytes pass; wider or multiple fail.
	task automatic t_set();
		logic [15:0] n[4] = '{16'h0001, 16'h0001, 16'h0002, 16'h0001};
		logic [7:0] b[4] = '{8'h1D, 8'h1E, 8'h04, 8'h01};
		for (int i = 0; i < 4; i++) begin
			@(negedge clk_i);
			tbl_set_i = 1'b1;
			tbl_set_entries_i = n[i];
			tbl_entry_bytes_i = b[i];
			@(negedge clk_i);
			tbl_set_i = 1'b0;
			tbl_set_entries_i = ~n[i];
			tbl_entry_bytes_i = ~b[i];
			chk_b(tbl_set_ok_o, i == 0 || i == 3, "set ok");
			chk_b(tbl_set_reject_o, i == 1 || i == 2, "set refused");
		end
		$display("table set test done");
	endtask

	initial begin
		repeat (10) @(negedge clk_i);
		rst_b_i = 1'b1;
		chk_v(config_change_seq_o, 8'h00, "seq at reset");
		chk_v(alarm_seq_o, 8'h01, "alarm seq at reset");
		t_cfg();
		t_alarm();
		t_sess(1);
		t_sess(0);
		t_sess(2);
		t_set();
		stop_test();
	end
endmodule
